// >>> pkg/mpscc_pkg.sv
// Constants, types and register map of the MII collision and carrier block
package mpscc_pkg;
  // Clock rates in kHz, core clock period in ps
  localparam int CORE_KHZ = 200000;
  localparam int FAST_KHZ = 25000;
  localparam int SLOW_KHZ = 2500;
  localparam int CORE_PS = 5000;
  localparam logic [5:0] FAST_HALF = 6'(CORE_KHZ / (2 * FAST_KHZ));
  localparam logic [5:0] SLOW_HALF = 6'(CORE_KHZ / (2 * SLOW_KHZ));
  // Times in ns or in 10 Mb/s bit times, with their core cycle counts
  localparam int BIT10_NS = 100;
  localparam int QUAL_BITS = 7;
  localparam int HB_DELAY_NS = 1000;
  localparam int HB_LEN_BITS = 10;
  localparam int BIT10_CYC = (BIT10_NS * 1000) / CORE_PS;
  localparam logic [7:0] QUAL_CYC = 8'(QUAL_BITS * BIT10_CYC);
  localparam logic [7:0] HB_WAIT_CYC = 8'((HB_DELAY_NS * 1000) / CORE_PS);
  localparam logic [7:0] HB_LEN_CYC = 8'(HB_LEN_BITS * BIT10_CYC);
  localparam logic [1:0] STRAP_TAKE = 2'h2;
  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int CTRL_W = 6;
  localparam int CTRL_SPEED = 0;
  localparam int CTRL_FULL = 1;
  localparam int CTRL_HB = 2;
  localparam int CTRL_OVR = 3;
  localparam int CTRL_MODE = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h01;
  localparam int STAT_CRS = 0;
  localparam int STAT_COL = 1;
  localparam int STAT_MODE = 2;
  localparam int STAT_STRAP = 4;
  // MAC interface modes
  localparam logic [1:0] MODE_MII = 2'h0;
  localparam logic [1:0] MODE_RMII = 2'h1;
  localparam logic [1:0] MODE_SINGLE_CLOCK_NIBBLE = 2'h2;

  typedef struct packed {
    logic [3:0] nib;
    logic dv;
    logic er;
  } mpscc_rx_s;

  typedef struct packed {
    logic [3:0] nib;
    logic en;
  } mpscc_tx_s;

  typedef enum logic [1:0] {Z_NONE, Z_ZERO, Z_GAP} mpscc_zero_e;
  typedef enum logic [1:0] {HB_IDLE, HB_WAIT, HB_PULSE} mpscc_hb_e;
endpackage

// >>> logic/mpscc_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module mpscc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// >>> logic/mpscc_mii_top.sv
// PHY-side MII data interface with collision and carrier sense
`timescale 1ns/10ps
module mpscc_mii_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // MII pins toward the MAC
  output logic rx_clk,
  output mpscc_pkg::mpscc_rx_s mii_rx,
  output logic tx_clk,
  input wire logic [3:0] txd,
  input wire logic tx_en,
  output logic crs,
  output logic col,
  // Mode strap pins
  input wire logic [1:0] mode_strap,
  // Line-side receive path
  input wire mpscc_pkg::mpscc_rx_s line_rx,
  input wire logic line_rx_act,
  input wire logic line_eop,
  input wire logic squelch_ok,
  input wire logic link_valid_detect,
  input wire logic line_bit_stb,
  input wire logic line_bit,
  // Line-side transmit path and mode
  output mpscc_pkg::mpscc_tx_s line_tx,
  output logic [1:0] mac_mode
);
  logic [mpscc_pkg::CTRL_W-1:0] ctrl_q;
  logic [31:0] rdata_q;
  logic [5:0] div_q;
  logic [5:0] half_m1;
  logic mclk_q;
  logic toggle;
  logic rise_ev;
  logic fall_ev;
  logic [6:0] sync_q;
  logic [3:0] txd_s;
  logic tx_en_s;
  logic [1:0] strap_s;
  mpscc_pkg::mpscc_tx_s tx_q;
  mpscc_pkg::mpscc_rx_s rx_q;
  logic tx_en_q;
  logic tx_prev_q;
  logic speed_100;
  logic full_dup;
  logic hb_en;
  mpscc_pkg::mpscc_zero_e zero_q;
  logic set_10;
  logic set_100;
  logic rx_car_q;
  logic col_cond;
  logic rx_first_q;
  logic [7:0] qual_q;
  logic qual_ok;
  mpscc_pkg::mpscc_hb_e hb_q;
  logic [7:0] hb_cnt_q;
  logic hb_ok;
  logic col_q;
  logic crs_q;
  logic [1:0] strap_cnt_q;
  logic [1:0] strap_q;
  logic strap_done_q;
  logic [1:0] mode_q;

  assign speed_100 = ctrl_q[mpscc_pkg::CTRL_SPEED];
  assign full_dup = ctrl_q[mpscc_pkg::CTRL_FULL];
  assign hb_en = ctrl_q[mpscc_pkg::CTRL_HB];

  // Register port
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= mpscc_pkg::CTRL_RST;
    end else if (reg_wr && reg_addr == mpscc_pkg::REG_CTRL) begin
      ctrl_q <= reg_wdata[mpscc_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= 32'h0;
      if (reg_rd && reg_addr == mpscc_pkg::REG_CTRL) begin
        rdata_q[mpscc_pkg::CTRL_W-1:0] <= ctrl_q;
      end else if (reg_rd && reg_addr == mpscc_pkg::REG_STAT) begin
        rdata_q[mpscc_pkg::STAT_CRS] <= crs_q;
        rdata_q[mpscc_pkg::STAT_COL] <= col_q;
        rdata_q[mpscc_pkg::STAT_MODE +: 2] <= mode_q;
        rdata_q[mpscc_pkg::STAT_STRAP] <= strap_done_q;
      end
    end
  end

  // MII clock divider; one clock serves both directions
  assign half_m1 = speed_100 ? mpscc_pkg::FAST_HALF - 6'h01
                             : mpscc_pkg::SLOW_HALF - 6'h01;
  assign toggle = (div_q >= half_m1);
  assign rise_ev = toggle & ~mclk_q;
  assign fall_ev = toggle & mclk_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_q <= 6'h00;
      mclk_q <= 1'b0;
    end else if (toggle) begin
      div_q <= 6'h00;
      mclk_q <= ~mclk_q;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  // Pins from the MAC cross into core_clk before anything reads them
  mpscc_sync #(.W(7)) u_sync (
    .clk(core_clk),
    .rst(rst),
    .d({mode_strap, tx_en, txd}),
    .q(sync_q)
  );
  assign txd_s = sync_q[3:0];
  assign tx_en_s = sync_q[4];
  assign strap_s = sync_q[6:5];

  // Transmit nibble taken at our rising edge of tx_clk
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_q <= '0;
      tx_prev_q <= 1'b0;
    end else begin
      tx_prev_q <= tx_q.en;
      if (rise_ev) begin
        tx_q <= '{nib: txd_s, en: tx_en_s};
      end
    end
  end
  assign tx_en_q = tx_q.en;

  // Receive outputs change on the falling edge so the MAC sees them settled
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_q <= '0;
    end else if (fall_ev) begin
      rx_q <= line_rx;
    end
  end

  // Two zeros with at least one one between them
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      zero_q <= mpscc_pkg::Z_NONE;
    end else if (!link_valid_detect || line_eop) begin
      zero_q <= mpscc_pkg::Z_NONE;
    end else if (line_bit_stb) begin
      case (zero_q)
        mpscc_pkg::Z_NONE: begin
          if (!line_bit) begin
            zero_q <= mpscc_pkg::Z_ZERO;
          end
        end
        mpscc_pkg::Z_ZERO: begin
          if (line_bit) begin
            zero_q <= mpscc_pkg::Z_GAP;
          end
        end
        mpscc_pkg::Z_GAP: begin
          if (!line_bit) begin
            zero_q <= mpscc_pkg::Z_NONE;
          end
        end
        default: begin
          zero_q <= mpscc_pkg::Z_NONE;
        end
      endcase
    end
  end

  assign set_10 = ~speed_100 & line_rx_act & squelch_ok;
  assign set_100 = speed_100 & link_valid_detect & line_bit_stb & ~line_bit
                   & (zero_q == mpscc_pkg::Z_GAP);

  // End of packet wins so the carrier cannot outlive its packet
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_car_q <= 1'b0;
    end else if (line_eop || (speed_100 && !link_valid_detect)) begin
      rx_car_q <= 1'b0;
    end else if (set_10 || set_100) begin
      rx_car_q <= 1'b1;
    end
  end

  // Collision detection
  assign col_cond = ~full_dup & tx_en_q & rx_car_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_first_q <= 1'b0;
      qual_q <= 8'h00;
    end else if (!col_cond) begin
      rx_first_q <= rx_car_q & ~tx_en_q;
      qual_q <= 8'h00;
    end else if (qual_q != mpscc_pkg::QUAL_CYC) begin
      qual_q <= qual_q + 8'h01;
    end
  end

  // Noise filter only applies at 10 Mb/s when our transmit met a late receive
  assign qual_ok = speed_100 | rx_first_q
                   | (qual_q == mpscc_pkg::QUAL_CYC);
  assign hb_ok = hb_en & ~full_dup & ~speed_100;

  // Heartbeat after each packet at 10 Mb/s half duplex; a new packet cancels it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hb_q <= mpscc_pkg::HB_IDLE;
      hb_cnt_q <= 8'h00;
    end else begin
      case (hb_q)
        mpscc_pkg::HB_IDLE: begin
          hb_cnt_q <= 8'h00;
          if (tx_prev_q && !tx_en_q && hb_ok) begin
            hb_q <= mpscc_pkg::HB_WAIT;
          end
        end
        mpscc_pkg::HB_WAIT: begin
          if (tx_en_q) begin
            hb_q <= mpscc_pkg::HB_IDLE;
          end else if (hb_cnt_q == mpscc_pkg::HB_WAIT_CYC - 8'h01) begin
            hb_q <= mpscc_pkg::HB_PULSE;
            hb_cnt_q <= 8'h00;
          end else begin
            hb_cnt_q <= hb_cnt_q + 8'h01;
          end
        end
        mpscc_pkg::HB_PULSE: begin
          if (tx_en_q || hb_cnt_q == mpscc_pkg::HB_LEN_CYC - 8'h01) begin
            hb_q <= mpscc_pkg::HB_IDLE;
          end else begin
            hb_cnt_q <= hb_cnt_q + 8'h01;
          end
        end
        default: begin
          hb_q <= mpscc_pkg::HB_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      col_q <= 1'b0;
      crs_q <= 1'b0;
    end else begin
      col_q <= (col_cond & qual_ok)
               | ((hb_q == mpscc_pkg::HB_PULSE) & hb_ok);
      crs_q <= rx_car_q | (~full_dup & tx_en_q);
    end
  end

  // Strap is taken once the synchroniser holds real pin values
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strap_cnt_q <= 2'h0;
      strap_q <= mpscc_pkg::MODE_MII;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == mpscc_pkg::STRAP_TAKE) begin
        strap_q <= strap_s;
        strap_done_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_q <= mpscc_pkg::MODE_MII;
    end else if (ctrl_q[mpscc_pkg::CTRL_OVR]) begin
      mode_q <= ctrl_q[mpscc_pkg::CTRL_MODE +: 2];
    end else begin
      mode_q <= strap_q;
    end
  end

  assign reg_rdata = rdata_q;
  assign rx_clk = mclk_q;
  assign tx_clk = mclk_q;
  assign mii_rx = rx_q;
  assign line_tx = tx_q;
  assign crs = crs_q;
  assign col = col_q;
  assign mac_mode = mode_q;

  // Speed must hold over the whole half period; a switch leaves the divider count running
  a_clk_fast_half: assert property (@(posedge core_clk) disable iff (rst)
    ($rose(mclk_q) && speed_100) ##1 speed_100[*3]
    |=> !mclk_q && $past(mclk_q) && $past(mclk_q, 2) && $past(mclk_q, 3))
    else $error("fast MII clock half period wrong");
  a_tx_rise_take: assert property (@(posedge core_clk) disable iff (rst)
    rise_ev |=> tx_q.en == $past(tx_en_s) && tx_q.nib == $past(txd_s))
    else $error("transmit not taken at rising edge");
  a_rx_fall_only: assert property (@(posedge core_clk) disable iff (rst)
    !fall_ev |=> $stable(rx_q))
    else $error("receive outputs moved off the falling edge");
  a_full_no_col: assert property (@(posedge core_clk) disable iff (rst)
    full_dup && $stable(full_dup) && hb_q == mpscc_pkg::HB_IDLE |=> !col_q)
    else $error("collision shown in full duplex");
  a_fast_col_now: assert property (@(posedge core_clk) disable iff (rst)
    col_cond && speed_100 |=> col_q)
    else $error("100 Mb/s collision not shown");
  a_rx_col_now: assert property (@(posedge core_clk) disable iff (rst)
    col_cond && rx_first_q |=> col_q)
    else $error("collision during receive delayed");
  a_slow_col_wait: assert property (@(posedge core_clk) disable iff (rst)
    $rose(col_cond) && !rx_first_q && !speed_100 && $stable(ctrl_q)
    && hb_q != mpscc_pkg::HB_PULSE |=> !col_q[*8])
    else $error("10 Mb/s transmit collision not held off");
  a_col_ends: assert property (@(posedge core_clk) disable iff (rst)
    !col_cond && hb_q != mpscc_pkg::HB_PULSE |=> !col_q)
    else $error("collision outlived its cause");
  a_hb_pulse_col: assert property (@(posedge core_clk) disable iff (rst)
    hb_q == mpscc_pkg::HB_PULSE && hb_ok |=> col_q)
    else $error("heartbeat pulse missing on col");
  a_sq_carrier: assert property (@(posedge core_clk) disable iff (rst)
    set_10 && !line_eop |=> rx_car_q ##1 crs_q)
    else $error("10 Mb/s carrier not raised");
  a_zero_carrier: assert property (@(posedge core_clk) disable iff (rst)
    set_100 && !line_eop |=> rx_car_q)
    else $error("100 Mb/s carrier not raised");
  a_half_tx_crs: assert property (@(posedge core_clk) disable iff (rst)
    !full_dup && tx_en_q |=> crs_q)
    else $error("carrier missing during transmit");
  a_full_rx_crs: assert property (@(posedge core_clk) disable iff (rst)
    full_dup && !rx_car_q |=> !crs_q)
    else $error("carrier from transmit in full duplex");
  a_eop_crs_drop: assert property (@(posedge core_clk) disable iff (rst)
    line_eop && (full_dup || !tx_en_q) && $stable(full_dup)
    |=> !rx_car_q ##1 !crs_q)
    else $error("carrier held after end of packet");
  a_mode_reg: assert property (@(posedge core_clk) disable iff (rst)
    ctrl_q[mpscc_pkg::CTRL_OVR]
    |=> mode_q == $past(ctrl_q[mpscc_pkg::CTRL_MODE +: 2]))
    else $error("register mode not applied");
endmodule

// >>> sim/mpscc_mac_model.sv
// Behavioural MAC model: drives transmit nibbles, samples receive data
`timescale 1ns/10ps
module mpscc_mac_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // MII pins
  input wire logic tx_clk,
  input wire logic rx_clk,
  input wire mpscc_pkg::mpscc_rx_s mii_rx,
  output logic [3:0] txd,
  output logic tx_en,
  // Bench control
  input wire logic go,
  input wire logic [7:0] len,
  output mpscc_pkg::mpscc_rx_s rx_seen
);
  logic [7:0] cnt_q;
  logic tx_clk_q;
  logic rx_clk_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      tx_clk_q <= 1'b0;
      txd <= 4'h0;
      tx_en <= 1'b0;
    end else begin
      tx_clk_q <= tx_clk;
      if (go) begin
        cnt_q <= len;
      end else if (tx_clk && !tx_clk_q) begin
        if (cnt_q != 8'h00) begin
          txd <= cnt_q[3:0];
          tx_en <= 1'b1;
          cnt_q <= cnt_q - 8'h01;
        end else begin
          // Idle nibble toggles so stale data can never pass for a match
          txd <= ~txd;
          tx_en <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_clk_q <= 1'b0;
      rx_seen <= '0;
    end else begin
      rx_clk_q <= rx_clk;
      if (rx_clk && !rx_clk_q) begin
        rx_seen <= mii_rx;
      end
    end
  end
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the MII collision and carrier block
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] CT = mpscc_pkg::REG_CTRL;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic rx_clk, tx_clk, crs, col, tx_en;
  logic [3:0] txd;
  logic [1:0] mac_mode;
  mpscc_pkg::mpscc_rx_s mii_rx, rx_seen;
  mpscc_pkg::mpscc_rx_s line_rx = 6'h00;
  mpscc_pkg::mpscc_tx_s line_tx;
  logic line_rx_act = 1'b0, line_eop = 1'b0, squelch_ok = 1'b0;
  logic link_valid_detect = 1'b0, line_bit_stb = 1'b0, line_bit = 1'b1;
  logic go = 1'b0;
  logic [7:0] len = 8'h00;
  logic [31:0] d, e;
  int n, mismatches = 0, n_compared = 0;

  always #2.5 core_clk = ~core_clk;

  mpscc_mii_top u_mpscc_mii_top (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_clk(rx_clk),
    .mii_rx(mii_rx), .tx_clk(tx_clk), .txd(txd), .tx_en(tx_en), .crs(crs),
    .col(col), .mode_strap(mpscc_pkg::MODE_SINGLE_CLOCK_NIBBLE),
    .line_rx(line_rx), .line_rx_act(line_rx_act), .line_eop(line_eop),
    .squelch_ok(squelch_ok), .link_valid_detect(link_valid_detect),
    .line_bit_stb(line_bit_stb), .line_bit(line_bit), .line_tx(line_tx),
    .mac_mode(mac_mode));

  mpscc_mac_model u_mpscc_mac_model (.core_clk(core_clk), .rst(rst),
    .tx_clk(tx_clk), .rx_clk(rx_clk), .mii_rx(mii_rx), .txd(txd),
    .tx_en(tx_en), .go(go), .len(len), .rx_seen(rx_seen));

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rng(input int k, input int lo, input int hi);
    n_compared++;
    if (k < lo || k > hi) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, k, lo);
    end
  endtask

  function automatic logic sel(input int w);
    case (w)
      0: sel = col;
      1: sel = crs;
      2: sel = rx_clk;
      3: sel = tx_clk;
      default: sel = line_tx.en;
    endcase
  endfunction

  // Counts core cycles until the chosen output reaches v; a hang ends the run
  task automatic wait_for(input int w, input logic v, input int lim,
                          output int k);
    k = 0;
    while (sel(w) !== v && k < lim) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (sel(w) !== v) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, sel(w), v);
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  function automatic logic [31:0] ctl(input logic sp, fd, hb);
    ctl = 32'h0;
    ctl[mpscc_pkg::CTRL_SPEED] = sp;
    ctl[mpscc_pkg::CTRL_FULL] = fd;
    ctl[mpscc_pkg::CTRL_HB] = hb;
  endfunction

  task automatic send(input logic [7:0] l);
    @(posedge core_clk);
    len <= l;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
  endtask

  // Zero, one, zero on the line: two zeros that are not adjacent
  task automatic zeros();
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      line_bit_stb <= 1'b1;
      line_bit <= (i == 1);
      @(posedge core_clk);
      line_bit_stb <= 1'b0;
    end
  endtask

  task automatic eop();
    @(posedge core_clk);
    line_eop <= 1'b1;
    line_rx_act <= 1'b0;
    squelch_ok <= 1'b0;
    link_valid_detect <= 1'b0;
    @(posedge core_clk);
    line_eop <= 1'b0;
  endtask

  task automatic clk_chk(input logic [5:0] h);
    for (int w = 2; w < 4; w++) begin
      wait_for(w, 1'b0, 100, n);
      wait_for(w, 1'b1, 100, n);
      wait_for(w, 1'b0, 100, n);
      chk(32'(n), 32'(h));
    end
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    chk(32'(mac_mode), 32'(mpscc_pkg::MODE_SINGLE_CLOCK_NIBBLE));
    rd(CT, d);
    chk(d, 32'(mpscc_pkg::CTRL_RST));
    rd(mpscc_pkg::REG_STAT, d);
    e = (32'(mpscc_pkg::MODE_SINGLE_CLOCK_NIBBLE) << mpscc_pkg::STAT_MODE)
        | (32'h1 << mpscc_pkg::STAT_STRAP);
    chk(d, e);
    wr(8'h08, 32'hffffffff);
    rd(8'h08, d);
    chk(d, 32'h0);
    e = (32'h1 << mpscc_pkg::CTRL_OVR)
        | (32'(mpscc_pkg::MODE_RMII) << mpscc_pkg::CTRL_MODE);
    wr(CT, e | ctl(1'b1, 1'b0, 1'b0));
    repeat (3) @(posedge core_clk);
    #1;
    chk(32'(mac_mode), 32'(mpscc_pkg::MODE_RMII));
    $display("test registers finished");
    clk_chk(mpscc_pkg::FAST_HALF);
    @(posedge core_clk);
    line_rx <= 6'h2b;
    repeat (20) @(posedge core_clk);
    #1;
    chk(32'(rx_seen), 32'h2b);
    $display("test clocks finished");
    wr(CT, ctl(1'b1, 1'b1, 1'b0));
    send(8'h0f);
    wait_for(4, 1'b1, 40, n);
    chk(32'(line_tx.nib), 32'hf);
    // Carrier from transmit would show one cycle after enable; look past it
    repeat (2) @(posedge core_clk);
    #1;
    chk(32'(crs), 32'h0);
    @(posedge core_clk);
    link_valid_detect <= 1'b1;
    zeros();
    wait_for(1, 1'b1, 4, n);
    repeat (4) @(posedge core_clk);
    #1;
    chk(32'(col), 32'h0);
    eop();
    wait_for(1, 1'b0, 4, n);
    wait_for(4, 1'b0, 200, n);
    $display("test full duplex finished");
    wr(CT, ctl(1'b1, 1'b0, 1'b0));
    send(8'h0f);
    wait_for(4, 1'b1, 40, n);
    wait_for(1, 1'b1, 3, n);
    @(posedge core_clk);
    link_valid_detect <= 1'b1;
    zeros();
    wait_for(0, 1'b1, 4, n);
    eop();
    wait_for(0, 1'b0, 4, n);
    wait_for(4, 1'b0, 200, n);
    $display("test fast collision finished");
    wr(CT, ctl(1'b0, 1'b0, 1'b0));
    clk_chk(mpscc_pkg::SLOW_HALF);
    @(posedge core_clk);
    line_rx_act <= 1'b1;
    squelch_ok <= 1'b1;
    wait_for(1, 1'b1, 4, n);
    send(8'h03);
    wait_for(4, 1'b1, 200, n);
    wait_for(0, 1'b1, 3, n);
    eop();
    wait_for(0, 1'b0, 4, n);
    wait_for(4, 1'b0, 400, n);
    send(8'h06);
    wait_for(4, 1'b1, 200, n);
    @(posedge core_clk);
    line_rx_act <= 1'b1;
    squelch_ok <= 1'b1;
    wait_for(0, 1'b1, 300, n);
    rng(n, 140, 146);
    eop();
    wait_for(0, 1'b0, 4, n);
    wait_for(4, 1'b0, 600, n);
    $display("test slow collision finished");
    wr(CT, ctl(1'b0, 1'b0, 1'b1));
    send(8'h02);
    wait_for(4, 1'b1, 200, n);
    wait_for(4, 1'b0, 200, n);
    wait_for(0, 1'b1, 300, n);
    rng(n, 195, 205);
    wait_for(0, 1'b0, 300, n);
    rng(n, 195, 205);
    $display("test heartbeat finished");
    complete_run();
  end
endmodule
